// ==== rtl/timer_pkg.sv ====
// Package for the 16-bit standard timer: register map, field layout,
// reset values and mode encodings.
// Assumes a byte-wide register port with a three-bit address.
package timer_pkg;

  // Register byte offsets on the register port.
  localparam logic [2:0] OFS_CONTROL_0 = 3'h0;
  localparam logic [2:0] OFS_CONTROL_1 = 3'h1;
  localparam logic [2:0] OFS_COUNT_LOW = 3'h2;
  localparam logic [2:0] OFS_COUNT_HIGH = 3'h3;
  localparam logic [2:0] OFS_CMP_A_LOW = 3'h4;
  localparam logic [2:0] OFS_CMP_A_HIGH = 3'h5;
  localparam logic [2:0] OFS_CMP_P = 3'h6;
  localparam logic [2:0] OFS_FLAGS = 3'h7;

  // Field positions in timer_control_0.
  localparam int POS_PAUSE = 7;
  localparam int POS_CLK_SEL_HI = 6;
  localparam int POS_CLK_SEL_LO = 4;
  localparam int POS_ENABLE = 3;

  // Field positions in timer_control_1.
  localparam int POS_MODE_HI = 7;
  localparam int POS_MODE_LO = 6;
  localparam int POS_PIN_FN_HI = 5;
  localparam int POS_PIN_FN_LO = 4;
  localparam int POS_OUT_CTRL = 3;
  localparam int POS_POLARITY = 2;
  localparam int POS_DUTY_SEL = 1;
  localparam int POS_CLEAR_SEL = 0;

  // Field positions in the flag register.
  localparam int POS_FLAG_A = 0;
  localparam int POS_FLAG_P = 1;

  // Reset values.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [5:0] RST_PRESCALE = 6'h00;

  // Counter limits and the scaled zero value of compare value P.
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_STEP = 16'h0001;
  localparam logic [16:0] FULL_SPAN = 17'h1_0000;
  localparam logic [5:0] PRE_DIV4 = 6'h03;
  localparam logic [5:0] PRE_DIV16 = 6'h0f;
  localparam logic [5:0] PRE_DIV64 = 6'h3f;

  // Mode field encodings.
  localparam logic [1:0] MODE_COMPARE = 2'b00;
  localparam logic [1:0] MODE_UNDEF = 2'b01;
  localparam logic [1:0] MODE_PWM_PULSE = 2'b10;
  localparam logic [1:0] MODE_TIMER = 2'b11;

  // Pin function field encodings.
  localparam logic [1:0] PIN_FN_00 = 2'b00;
  localparam logic [1:0] PIN_FN_01 = 2'b01;
  localparam logic [1:0] PIN_FN_10 = 2'b10;
  localparam logic [1:0] PIN_FN_11 = 2'b11;

  // Counting clock sources.
  typedef enum logic [2:0] {
    CLK_SYS_DIV4 = 3'b000,
    CLK_SYS = 3'b001,
    CLK_HIGH_DIV16 = 3'b010,
    CLK_HIGH_DIV64 = 3'b011,
    CLK_SUB_A = 3'b100,
    CLK_SUB_B = 3'b101,
    CLK_EXT_RISE = 3'b110,
    CLK_EXT_FALL = 3'b111
  } clock_select_t;

endpackage

// ==== rtl/standard_timer.sv ====
// Standard 16-bit up-counting timer with comparators A and P, compare
// output, timer, PWM and single pulse modes, and a byte register port.
// Assumes the high clock equals the system clock, the sub clock and the
// external clock/trigger arrive asynchronously on pins.
//
// How it works
// - counter readable as two read-only bytes.
// - compare value A in two RW bytes.
// - P compares counter top byte, zero means 65536.
// - P match clears counter, P zero wraps.
// - mode field and pin field choose mode.
// - clear-select zero clears on P, both flags.
// - clear-select one clears on A, A flag only.
// - A zero overflows at FFFF, no A flag.
// - compare pin changes only on A flag or enable rise.
// - enable rise sets pin to initial level.
// - timer mode counts like compare, pin unused.
// - PWM ignores clear-select, duty select swaps roles.
// - duty not below period gives full duty.
// - PWM raises both flags on matches.
// - PWM polarity, forcing and inversion of the pin.
// - PWM keeps counting while pin forced.
// - pulse starts on enable rise.
// - trigger pin edge sets enable in pulse mode.
// - A match or software clear ends pulse.
// - pulse counter cleared only by enable rise.
// - enable rise zeroes counter, clear keeps count.
// - pause freezes counter, release resumes.
// - clock select picks the counting clock.
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module standard_timer
  import timer_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [2:0] address,
  input wire logic [7:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [7:0] read_data,
  input wire logic ext_clock_trigger_pin,
  input wire logic sub_clock_pin,
  output logic timer_output_pin,
  output logic timer_output_enable,
  output logic compare_a_flag,
  output logic compare_p_flag
);

  // Fewer than two stages would let a metastable level reach logic.
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("SYNC_STAGES must be at least 2");
  end

  // Single pulse is the PWM mode with the pin field at 11.
  function automatic logic is_pulse(input logic [1:0] m, input logic [1:0] f);
    is_pulse = (m == MODE_PWM_PULSE) && (f == PIN_FN_11);
  endfunction

  // Control fields.
  logic pause_bit;
  logic [2:0] clock_select_field;
  logic enable_bit;
  logic [1:0] mode_field;
  logic [1:0] pin_function_field;
  logic output_control_bit;
  logic polarity_bit;
  logic duty_period_select;
  logic clear_select_bit;
  // Compare values and the counter.
  logic [15:0] compare_value_a;
  logic [7:0] compare_value_p;
  logic [15:0] counter;
  // Enable history for rising edge detection.
  logic enable_prev;
  logic en_rise;
  // Free-running prescaler for the divided clocks.
  logic [5:0] prescale;
  // Synchronisers and edge history for the two pins.
  logic [SYNC_STAGES-1:0] ext_sync;
  logic [SYNC_STAGES-1:0] sub_sync;
  logic ext_prev;
  logic sub_prev;
  logic ext_rise;
  logic ext_fall;
  logic sub_rise;
  logic trig_edge;
  // Counting event, matches and their effects.
  logic tick;
  logic [15:0] inc;
  logic match_a;
  logic match_p;
  logic clear_cnt;
  logic set_a;
  logic set_p;
  // PWM duty and period in 17 bits so that 65536 fits.
  logic [16:0] p_scaled;
  logic [16:0] duty_val;
  logic [16:0] period_val;
  logic pwm_active;
  // Pin level before polarity, and the register-port decodes.
  logic pin_state;
  logic [1:0] next_pin_sel;
  logic wr_ctrl0;
  logic sw_pulse;

  assign en_rise = enable_bit && !enable_prev;
  assign wr_ctrl0 = write_strobe && (address == OFS_CONTROL_0);
  assign sw_pulse = is_pulse(mode_field, pin_function_field);
  assign next_pin_sel = pin_function_field;

  // Both pins pass a chain of flip-flops; only the last stage is read.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ext_sync <= '0;
      sub_sync <= '0;
      ext_prev <= 1'b0;
      sub_prev <= 1'b0;
    end else begin
      ext_sync <= {ext_sync[SYNC_STAGES-2:0], ext_clock_trigger_pin};
      sub_sync <= {sub_sync[SYNC_STAGES-2:0], sub_clock_pin};
      ext_prev <= ext_sync[SYNC_STAGES-1];
      sub_prev <= sub_sync[SYNC_STAGES-1];
    end
  end

  assign ext_rise = ext_sync[SYNC_STAGES-1] && !ext_prev;
  assign ext_fall = !ext_sync[SYNC_STAGES-1] && ext_prev;
  assign sub_rise = sub_sync[SYNC_STAGES-1] && !sub_prev;
  // The trigger uses the falling edge only when that source is selected.
  assign trig_edge = (clock_select_field == CLK_EXT_FALL) ? ext_fall : ext_rise;

  // Prescaler runs always so divided ticks are evenly spaced.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      prescale <= RST_PRESCALE;
    end else begin
      prescale <= prescale + 6'h01;
    end
  end

  // Counting clock event, gated by enable and pause.
  always_comb begin
    case (clock_select_t'(clock_select_field))
      CLK_SYS_DIV4: tick = (prescale[1:0] == PRE_DIV4[1:0]);
      CLK_SYS: tick = 1'b1;
      CLK_HIGH_DIV16: tick = (prescale[3:0] == PRE_DIV16[3:0]);
      CLK_HIGH_DIV64: tick = (prescale == PRE_DIV64);
      CLK_SUB_A: tick = sub_rise;
      CLK_SUB_B: tick = sub_rise;
      CLK_EXT_RISE: tick = ext_rise;
      default: tick = ext_fall;
    endcase
    tick = tick && enable_bit && !pause_bit && !en_rise;
  end

  // Comparators look at the value the counter is about to take.
  always_comb begin
    inc = counter + COUNT_STEP;
    match_a = tick && (compare_value_a != RST_WORD) && (inc == compare_value_a);
    if (compare_value_p != RST_BYTE) begin
      match_p = tick && (inc[15:8] == compare_value_p) && (inc[7:0] == RST_BYTE);
    end else begin
      match_p = tick && (counter == COUNT_MAX);
    end
  end

  // Mode decides which match clears the counter and which flags rise.
  always_comb begin
    clear_cnt = 1'b0;
    set_a = match_a;
    set_p = match_p;
    if (sw_pulse) begin
      set_p = 1'b0;
    end else if (mode_field == MODE_PWM_PULSE) begin
      clear_cnt = duty_period_select ? match_a : match_p;
    end else if (clear_select_bit) begin
      clear_cnt = match_a;
      set_p = 1'b0;
    end else begin
      clear_cnt = match_p;
    end
  end

  // Counter: zeroed on enable rise, otherwise steps or clears on a tick.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      counter <= RST_WORD;
      enable_prev <= 1'b0;
    end else begin
      enable_prev <= enable_bit;
      if (en_rise) begin
        counter <= RST_WORD;
      end else if (clear_cnt) begin
        counter <= RST_WORD;
      end else if (tick) begin
        counter <= inc;
      end
    end
  end

  // Control register 0, with enable also driven by trigger and A match.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pause_bit <= 1'b0;
      clock_select_field <= 3'b000;
      enable_bit <= 1'b0;
    end else begin
      if (wr_ctrl0) begin
        pause_bit <= write_data[POS_PAUSE];
        clock_select_field <= write_data[POS_CLK_SEL_HI:POS_CLK_SEL_LO];
      end
      // A trigger edge wins over an A match or a software clear.
      if (sw_pulse && trig_edge) begin
        enable_bit <= 1'b1;
      end else if (wr_ctrl0) begin
        enable_bit <= write_data[POS_ENABLE];
      end else if (sw_pulse && match_a) begin
        enable_bit <= 1'b0;
      end
    end
  end

  // Control register 1 and the compare values.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mode_field <= MODE_COMPARE;
      pin_function_field <= PIN_FN_00;
      output_control_bit <= 1'b0;
      polarity_bit <= 1'b0;
      duty_period_select <= 1'b0;
      clear_select_bit <= 1'b0;
      compare_value_a <= RST_WORD;
      compare_value_p <= RST_BYTE;
    end else if (write_strobe) begin
      if (address == OFS_CONTROL_1) begin
        mode_field <= write_data[POS_MODE_HI:POS_MODE_LO];
        pin_function_field <= write_data[POS_PIN_FN_HI:POS_PIN_FN_LO];
        output_control_bit <= write_data[POS_OUT_CTRL];
        polarity_bit <= write_data[POS_POLARITY];
        duty_period_select <= write_data[POS_DUTY_SEL];
        clear_select_bit <= write_data[POS_CLEAR_SEL];
      end else if (address == OFS_CMP_A_LOW) begin
        compare_value_a[7:0] <= write_data;
      end else if (address == OFS_CMP_A_HIGH) begin
        compare_value_a[15:8] <= write_data;
      end else if (address == OFS_CMP_P) begin
        compare_value_p <= write_data;
      end
    end
  end

  // Duty and period in PWM mode; a duty not below the period is full on.
  always_comb begin
    p_scaled = (compare_value_p == RST_BYTE) ? FULL_SPAN : {1'b0, compare_value_p, RST_BYTE};
    duty_val = duty_period_select ? p_scaled : {1'b0, compare_value_a};
    period_val = duty_period_select ? {1'b0, compare_value_a} : p_scaled;
    pwm_active = (duty_val >= period_val) || ({1'b0, counter} < duty_val);
  end

  // Pin level before polarity, per mode.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pin_state <= 1'b0;
    end else if (mode_field == MODE_PWM_PULSE) begin
      if (sw_pulse) begin
        pin_state <= enable_bit ? output_control_bit : !output_control_bit;
      end else if (next_pin_sel == PIN_FN_00) begin
        pin_state <= !output_control_bit;
      end else if (next_pin_sel == PIN_FN_01) begin
        pin_state <= output_control_bit;
      end else begin
        pin_state <= pwm_active ? output_control_bit : !output_control_bit;
      end
    end else if (mode_field == MODE_COMPARE) begin
      if (en_rise) begin
        pin_state <= output_control_bit;
      end else if (set_a) begin
        if (next_pin_sel == PIN_FN_01) begin
          pin_state <= 1'b0;
        end else if (next_pin_sel == PIN_FN_10) begin
          pin_state <= 1'b1;
        end else if (next_pin_sel == PIN_FN_11) begin
          pin_state <= !pin_state;
        end
      end
    end
  end

  // Pin drivers; the pin is released in timer mode and the undefined mode.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      timer_output_pin <= 1'b0;
      timer_output_enable <= 1'b0;
    end else begin
      timer_output_pin <= pin_state ^ polarity_bit;
      timer_output_enable <= (mode_field == MODE_COMPARE) || (mode_field == MODE_PWM_PULSE);
    end
  end

  // Sticky flags; a write of one clears, a hardware set in the same cycle wins.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      compare_a_flag <= 1'b0;
      compare_p_flag <= 1'b0;
    end else begin
      if (set_a) begin
        compare_a_flag <= 1'b1;
      end else if (write_strobe && (address == OFS_FLAGS) && write_data[POS_FLAG_A]) begin
        compare_a_flag <= 1'b0;
      end
      if (set_p) begin
        compare_p_flag <= 1'b1;
      end else if (write_strobe && (address == OFS_FLAGS) && write_data[POS_FLAG_P]) begin
        compare_p_flag <= 1'b0;
      end
    end
  end

  // Read port: data stand one cycle after the read strobe, zero otherwise.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      read_data <= RST_BYTE;
    end else if (!read_strobe) begin
      read_data <= RST_BYTE;
    end else if (address == OFS_CONTROL_0) begin
      read_data <= {pause_bit, clock_select_field, enable_bit, 3'b000};
    end else if (address == OFS_CONTROL_1) begin
      read_data <= {mode_field, pin_function_field, output_control_bit, polarity_bit,
                    duty_period_select, clear_select_bit};
    end else if (address == OFS_COUNT_LOW) begin
      read_data <= counter[7:0];
    end else if (address == OFS_COUNT_HIGH) begin
      read_data <= counter[15:8];
    end else if (address == OFS_CMP_A_LOW) begin
      read_data <= compare_value_a[7:0];
    end else if (address == OFS_CMP_A_HIGH) begin
      read_data <= compare_value_a[15:8];
    end else if (address == OFS_CMP_P) begin
      read_data <= compare_value_p;
    end else begin
      read_data <= {6'b000000, compare_p_flag, compare_a_flag};
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  // Named steps used by the checks below.
  sequence s_enable_rise;
    en_rise;
  endsequence

  sequence s_pulse_match;
    sw_pulse && match_a && !trig_edge && !wr_ctrl0;
  endsequence

  AST_COUNTER_ZERO_ON_RISE: assert property (s_enable_rise |=> counter == RST_WORD)
    else $error("counter not zero after enable rise");

  AST_PAUSE_FREEZE: assert property (enable_bit && pause_bit && !en_rise |=> $stable(counter))
    else $error("counter moved while paused");

  AST_NO_P_FLAG_CLEAR_A: assert property (mode_field != MODE_PWM_PULSE && clear_select_bit |-> !set_p)
    else $error("P flag set with clear-select one");

  AST_A_ZERO_NO_FLAG: assert property (compare_value_a == RST_WORD |-> !set_a)
    else $error("A flag set with A zero");

  AST_P_CLEARS: assert property (mode_field == MODE_COMPARE && !clear_select_bit && match_p |=> counter == RST_WORD)
    else $error("P match did not clear counter");

  AST_PULSE_END: assert property (s_pulse_match |=> !enable_bit ##2 timer_output_pin == (!output_control_bit ^ polarity_bit))
    else $error("pulse did not end on A match");

  AST_TRIGGER_SETS: assert property (sw_pulse && trig_edge |=> enable_bit)
    else $error("trigger edge did not set enable");

  AST_PWM_FULL: assert property (mode_field == MODE_PWM_PULSE && next_pin_sel == PIN_FN_10 && duty_val >= period_val
    |=> pin_state == output_control_bit)
    else $error("full duty not held");

  AST_INIT_LEVEL: assert property (s_enable_rise and (mode_field == MODE_COMPARE) |=> pin_state == output_control_bit ##1
    timer_output_pin == (output_control_bit ^ polarity_bit))
    else $error("pin not at initial level after enable rise");

  AST_FORCE_ACTIVE: assert property (mode_field == MODE_PWM_PULSE && next_pin_sel == PIN_FN_01
    |=> pin_state == output_control_bit)
    else $error("forced active level not held");

endmodule

`default_nettype wire

// ==== tb/pin_partner.sv ====
// Far-side model of the timer pins: a free-running sub clock and an
// external clock/trigger line that idles low between requested pulses.
// Assumes its clock is the system clock that runs the timer.
`timescale 1ns/1ps
`default_nettype none

module pin_partner (
  input wire logic clock,
  output logic sub_clock_pin,
  output var logic ext_clock_trigger_pin
);
  // Divider that paces the sub clock at one sixteenth of the system clock.
  logic [3:0] sub_div = 4'h0;

  initial ext_clock_trigger_pin = 1'b0;

  // The sub clock runs free, unrelated to any transfer.
  always @(posedge clock) begin
    sub_div <= sub_div + 4'h1;
  end
  assign sub_clock_pin = sub_div[3];

  // One full pulse: a rising then a falling edge, each level held long
  // enough to pass the synchroniser.
  task automatic send_pulse();
    @(posedge clock);
    ext_clock_trigger_pin <= 1'b1;
    repeat (6) @(posedge clock);
    ext_clock_trigger_pin <= 1'b0;
    repeat (6) @(posedge clock);
  endtask
endmodule

`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench of the standard timer through its register port.
// Assumes the pin partner drives both input pins of the timer.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import timer_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] address = 3'h0;
  logic [7:0] write_data = 8'h00;
  logic write_strobe = 1'b0;
  logic read_strobe = 1'b0;
  logic [7:0] read_data;
  logic ext_clock_trigger_pin;
  logic sub_clock_pin;
  logic timer_output_pin;
  logic timer_output_enable;
  logic compare_a_flag;
  logic compare_p_flag;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  logic [7:0] rv;
  logic [15:0] v1;
  logic [15:0] v2;
  int h;

  // The system clock at 40 MHz.
  always #12.5 clock = ~clock;

  standard_timer i_standard_timer (.clock(clock), .reset_n(reset_n), .address(address),
    .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
    .read_data(read_data), .ext_clock_trigger_pin(ext_clock_trigger_pin),
    .sub_clock_pin(sub_clock_pin), .timer_output_pin(timer_output_pin),
    .timer_output_enable(timer_output_enable), .compare_a_flag(compare_a_flag),
    .compare_p_flag(compare_p_flag));

  pin_partner i_pin_partner (.clock(clock), .sub_clock_pin(sub_clock_pin),
    .ext_clock_trigger_pin(ext_clock_trigger_pin));

  // Prints the verdict and ends the run.
  task automatic give_verdict();
    if (miscompares == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // A hung wait is cut short well after all scenarios should be done.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 95000) begin
      miscompares++;
      give_verdict();
    end
  end

  // Compares one value with its expectation.
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Checks that a value lies in a closed range.
  task automatic check_in(input string what, input logic [15:0] v, input logic [15:0] lo,
    input logic [15:0] hi);
    check(what, {15'h0000, (v >= lo) && (v <= hi)}, 16'h0001);
  endtask

  // One register write cycle.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask

  // One register read cycle; the data are taken in the cycle after the strobe.
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1;
    d = read_data;
  endtask

  // Reads the counter as two separate bytes.
  task automatic rd_cnt(output logic [15:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(OFS_COUNT_LOW, lo);
    rd(OFS_COUNT_HIGH, hi);
    v = {hi, lo};
  endtask

  // Lets n edges pass and settles just after the last one.
  task automatic pass_n(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Counts the cycles in which the output pin is high.
  task automatic count_high(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge clock);
      #1;
      if (timer_output_pin === 1'b1) c++;
    end
  endtask

  // Stops the timer, clears the flags, sets the mode and starts on the system clock.
  task automatic start(input logic [7:0] c1);
    wr(OFS_CONTROL_0, 8'h00);
    wr(OFS_FLAGS, 8'h03);
    wr(OFS_CONTROL_1, c1);
    wr(OFS_CONTROL_0, 8'h18);
  endtask

  // Reset values, read-only counter bytes and read/write compare bytes.
  task automatic t_reset();
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), rv);
      check("reset value", {8'h00, rv}, 16'h0000);
    end
    wr(OFS_COUNT_LOW, 8'h55);
    wr(OFS_COUNT_HIGH, 8'haa);
    rd_cnt(v1);
    check("counter write ignored", v1, 16'h0000);
    wr(OFS_CMP_A_LOW, 8'h34);
    wr(OFS_CMP_A_HIGH, 8'h12);
    rd(OFS_CMP_A_LOW, rv);
    check("compare a low", {8'h00, rv}, 16'h0034);
    rd(OFS_CMP_A_HIGH, rv);
    check("compare a high", {8'h00, rv}, 16'h0012);
  endtask

  // Compare mode clearing on A: initial level, then low on the A match.
  task automatic t_cmp_a();
    wr(OFS_CMP_A_LOW, 8'h05);
    wr(OFS_CMP_A_HIGH, 8'h00);
    wr(OFS_CMP_P, 8'h00);
    start(8'h19);
    pass_n(3);
    check("initial level", {15'h0000, timer_output_pin}, 16'h0001);
    check("pin driven", {15'h0000, timer_output_enable}, 16'h0001);
    pass_n(30);
    check("pin after a match", {15'h0000, timer_output_pin}, 16'h0000);
    check("a flag", {15'h0000, compare_a_flag}, 16'h0001);
    check("no p flag", {15'h0000, compare_p_flag}, 16'h0000);
    rd_cnt(v1);
    check_in("counter below a", v1, 16'h0000, 16'h0004);
  endtask

  // Compare mode clearing on P with toggling on A, then timer mode and the undefined mode.
  task automatic t_cmp_p(input logic [7:0] c1);
    wr(OFS_CMP_A_LOW, 8'h10);
    wr(OFS_CMP_P, 8'h01);
    start(c1);
    pass_n(600);
    check("both flags", {14'h0000, compare_p_flag, compare_a_flag}, 16'h0003);
    check("enable by mode", {15'h0000, timer_output_enable}, {15'h0000, c1 == 8'h30});
    rd_cnt(v1);
    check_in("counter below 256", v1, 16'h0000, 16'h00ff);
    if (c1 == 8'h30) begin
      count_high(512, h);
      check("toggle duty", 16'(h), 16'h0100);
    end
  endtask

  // A and P zero: the counter runs the full 65536 span, P flag only.
  task automatic t_overflow();
    wr(OFS_CMP_A_LOW, 8'h00);
    wr(OFS_CMP_P, 8'h00);
    start(8'hc0);
    pass_n(65000);
    check("no early wrap", {15'h0000, compare_p_flag}, 16'h0000);
    pass_n(700);
    check("wrap flags", {14'h0000, compare_p_flag, compare_a_flag}, 16'h0002);
  endtask

  // Pause freezes, disable keeps the count, enable rise zeroes it.
  task automatic t_pause();
    wr(OFS_CMP_A_HIGH, 8'h10);
    start(8'hc0);
    pass_n(50);
    wr(OFS_CONTROL_0, 8'h98);
    rd_cnt(v1);
    pass_n(10);
    rd_cnt(v2);
    check("paused count", v2, v1);
    wr(OFS_CONTROL_0, 8'h18);
    pass_n(10);
    rd_cnt(v2);
    check_in("resumed count", v2, v1 + 16'h0001, v1 + 16'h0020);
    wr(OFS_CONTROL_0, 8'h10);
    rd_cnt(v1);
    pass_n(10);
    rd_cnt(v2);
    check("stopped count", v2, v1);
    wr(OFS_CONTROL_0, 8'h18);
    rd_cnt(v2);
    check_in("restart count", v2, 16'h0000, 16'h0006);
  endtask

  // Internal and sub clock rates: about twenty steps each.
  task automatic t_rate(input logic [7:0] c0, input int n);
    wr(OFS_CONTROL_0, 8'h00);
    wr(OFS_CONTROL_0, c0);
    pass_n(n);
    rd(OFS_COUNT_LOW, rv);
    check_in("rate count", {8'h00, rv}, 16'h0011, 16'h0015);
  endtask

  // External pin edges: five pulses give five steps.
  task automatic t_ext(input logic [7:0] c0);
    wr(OFS_CONTROL_0, 8'h00);
    wr(OFS_CONTROL_0, c0);
    repeat (5) i_pin_partner.send_pulse();
    pass_n(5);
    rd(OFS_COUNT_LOW, rv);
    check("edge count", {8'h00, rv}, 16'h0005);
  endtask

  // PWM with P at 1 and A at 64: high cycles over 512 clocks, two 256-clock periods when P sets the period.
  task automatic t_pwm(input logic [7:0] c1, input int high, input logic pf);
    wr(OFS_CMP_A_LOW, 8'h40);
    wr(OFS_CMP_A_HIGH, 8'h00);
    wr(OFS_CMP_P, 8'h01);
    start(c1);
    pass_n(20);
    count_high(512, h);
    check("pwm high cycles", 16'(h), 16'(high));
    check("pwm flags", {14'h0000, compare_p_flag, compare_a_flag}, {14'h0000, pf, 1'b1});
  endtask

  // Single pulse started by the pin, ended by A; then by software.
  task automatic t_pulse();
    wr(OFS_CMP_A_LOW, 8'h20);
    wr(OFS_CONTROL_0, 8'h00);
    wr(OFS_FLAGS, 8'h03);
    wr(OFS_CONTROL_1, 8'hb8);
    wr(OFS_CONTROL_0, 8'h10);
    fork
      i_pin_partner.send_pulse();
      count_high(100, h);
    join
    check_in("pulse width", 16'(h), 16'h001e, 16'h0024);
    rd(OFS_CONTROL_0, rv);
    check("enable cleared", {15'h0000, rv[POS_ENABLE]}, 16'h0000);
    check("pulse a flag", {15'h0000, compare_a_flag}, 16'h0001);
    rd_cnt(v1);
    check_in("pulse count kept", v1, 16'h001f, 16'h0021);
    wr(OFS_CONTROL_0, 8'h18);
    pass_n(3);
    check("leading edge", {15'h0000, timer_output_pin}, 16'h0001);
    wr(OFS_CONTROL_0, 8'h10);
    pass_n(3);
    check("trailing edge", {15'h0000, timer_output_pin}, 16'h0000);
  endtask

  // Main sequence: reset for twenty cycles, then each scenario in turn.
  initial begin
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    t_reset();
    t_cmp_a();
    t_cmp_p(8'h30);
    t_cmp_p(8'hc0);
    t_cmp_p(8'h70);
    t_pause();
    t_rate(8'h08, 80);
    t_rate(8'h28, 320);
    t_rate(8'h38, 1280);
    t_rate(8'h48, 320);
    t_rate(8'h58, 320);
    t_ext(8'h68);
    t_ext(8'h78);
    t_pwm(8'ha8, 128, 1'b1);
    t_pwm(8'hac, 384, 1'b1);
    t_pwm(8'h88, 0, 1'b1);
    t_pwm(8'h98, 512, 1'b1);
    t_pwm(8'haa, 512, 1'b0);
    t_pulse();
    t_overflow();
    give_verdict();
  end
endmodule

`default_nettype wire
